// ===== rtl/awm_dev.sv
// Device end: long write and multiple write command execution
`include "awm_params.svh"
// Contract
// R1: long write carries 516 bytes, not 512
// R2: long write moves exactly one sector
// R3: 512 bytes as words, four check bytes bytewise
// R4: host check bytes dropped
// R5: 32h with retries, 33h without retries
// R6: busy raised within 400 ns of command
// R7: multiple write interrupts once per block only
// R8: host checks data-request only per block
// R9: host sets block size before multiple write
// R10: C5h runs as multi-sector write
// R11: start address from task-file registers
// R12: busy, then data-request, no interrupt
// R13: sector count zero means 256 sectors
// R14: busy after last sector, then interrupt
// R15: error stops at failing sector address
// R16: multiple write without block size aborts
module awm_dev (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // Task-file link
    awm_tf_if.dev tf,
    // Block size from set-multiple, zero when not configured
    input wire awm_pkg::awm_byte_t blk_sectors,
    // Media side: sector words, store request and answer
    output logic med_wvalid,
    output awm_pkg::awm_word_t med_wdata,
    output logic [27:0] med_lba,
    output logic med_lba_mode,
    output logic med_retry,
    output logic med_store,
    input wire logic med_ack,
    input wire logic med_fail
);
    import awm_pkg::*;

    localparam int BSY_MAX_CYC = `AWM_BSY_MAX_NS / `AWM_CLK_NS;
    if (BSY_MAX_CYC < 1) $error("clock too slow");

    awm_dst_t st_r, st_nxt;
    logic [7:0] sc_r, sc_nxt, sn_r, sn_nxt, cl_r, cl_nxt;
    logic [7:0] ch_r, ch_nxt, dh_r, dh_nxt, cmd_r, cmd_nxt;
    logic [7:0] er_r, er_nxt, blk_r, blk_nxt;
    logic bsy_r, bsy_nxt, drq_r, drq_nxt, errb_r, errb_nxt;
    logic irq_r, irq_nxt, long_r, long_nxt;
    logic [8:0] left_r, left_nxt, wcnt_r, wcnt_nxt;
    awm_word_t rd_r, rd_nxt, mwd_r, mwd_nxt;
    logic mwv_r, mwv_nxt, sto_r, sto_nxt;
    logic [27:0] lba_inc;
    logic data_wr, last_acc;

    // Opcode class: 1 long, 2 multiple, 0 unsupported
    function automatic logic [1:0] op_class(input logic [7:0] op);
        if (op == `AWM_OP_LONG_RTY || op == `AWM_OP_LONG_NORTY)
            op_class = 2'd1; // [R5]
        else if (op == `AWM_OP_MULT)
            op_class = 2'd2; // [R10]
        else
            op_class = 2'd0;
    endfunction : op_class

    // Start address assembled from the task file
    assign med_lba = {dh_r[3:0], ch_r, cl_r, sn_r}; // [R11]
    assign med_lba_mode = dh_r[`AWM_DH_LBA];
    assign med_retry = (cmd_r != `AWM_OP_LONG_NORTY); // [R5]
    assign lba_inc = med_lba + 28'h1;
    assign med_wvalid = mwv_r;
    assign med_wdata = mwd_r;
    assign med_store = sto_r;
    assign tf.tf_rdata = rd_r;
    assign tf.intrq = irq_r;
    // Host streams a whole block, so a pending store still takes words
    assign data_wr = tf.tf_wr && tf.tf_addr == `AWM_TF_DATA &&
                     st_r inside {D_XFER, D_STORE};
    // Long sector ends on its 260th access, others on the 256th
    assign last_acc = long_r ? (wcnt_r == `AWM_LONG_ACC - 9'd1) // [R1]
                             : (wcnt_r == `AWM_SECT_WORDS - 9'd1);

    // Next-state logic
    always_comb
    begin
        st_nxt = st_r;
        sc_nxt = sc_r;
        sn_nxt = sn_r;
        cl_nxt = cl_r;
        ch_nxt = ch_r;
        dh_nxt = dh_r;
        cmd_nxt = cmd_r;
        er_nxt = er_r;
        blk_nxt = blk_r;
        bsy_nxt = bsy_r;
        drq_nxt = drq_r;
        errb_nxt = errb_r;
        irq_nxt = irq_r;
        long_nxt = long_r;
        left_nxt = left_r;
        wcnt_nxt = wcnt_r;
        rd_nxt = rd_r;
        mwd_nxt = mwd_r;
        mwv_nxt = 1'b0;
        sto_nxt = sto_r;
        // Register reads answer one cycle later
        if (tf.tf_rd)
        begin
            if (tf.tf_addr == `AWM_TF_ERR)
                rd_nxt = {8'h00, er_r};
            else if (tf.tf_addr == `AWM_TF_SC)
                rd_nxt = {8'h00, sc_r};
            else if (tf.tf_addr == `AWM_TF_SN)
                rd_nxt = {8'h00, sn_r};
            else if (tf.tf_addr == `AWM_TF_CL)
                rd_nxt = {8'h00, cl_r};
            else if (tf.tf_addr == `AWM_TF_CH)
                rd_nxt = {8'h00, ch_r};
            else if (tf.tf_addr == `AWM_TF_DH)
                rd_nxt = {8'h00, dh_r};
            else if (tf.tf_addr == `AWM_TF_CMD)
            begin
                rd_nxt = 16'h0000;
                rd_nxt[`AWM_ST_BSY] = bsy_r;
                rd_nxt[`AWM_ST_DRDY] = 1'b1;
                rd_nxt[`AWM_ST_DSC] = 1'b1;
                rd_nxt[`AWM_ST_DRQ] = drq_r;
                rd_nxt[`AWM_ST_ERR] = errb_r;
                irq_nxt = 1'b0; // Status read acknowledges
            end
            else
                rd_nxt = 16'h0000;
        end
        // Non-data task-file writes only while idle; every non-idle state locks the file
        if (tf.tf_wr && st_r == D_IDLE)
        begin
            if (tf.tf_addr == `AWM_TF_SC)
                sc_nxt = tf.tf_wdata[7:0];
            else if (tf.tf_addr == `AWM_TF_SN)
                sn_nxt = tf.tf_wdata[7:0];
            else if (tf.tf_addr == `AWM_TF_CL)
                cl_nxt = tf.tf_wdata[7:0];
            else if (tf.tf_addr == `AWM_TF_CH)
                ch_nxt = tf.tf_wdata[7:0];
            else if (tf.tf_addr == `AWM_TF_DH)
                dh_nxt = tf.tf_wdata[7:0];
            else if (tf.tf_addr == `AWM_TF_CMD)
            begin
                cmd_nxt = tf.tf_wdata[7:0];
                bsy_nxt = 1'b1; // [R6] [R12]
                drq_nxt = 1'b0;
                errb_nxt = 1'b0;
                er_nxt = 8'h00;
                irq_nxt = 1'b0;
                st_nxt = D_SETUP;
            end
        end
        // Limitation: next sector must not end before the store answer
        if (data_wr)
        begin
            wcnt_nxt = wcnt_r + 9'd1;
            // Check bytes are swallowed, never forwarded [R4]
            if (wcnt_r < `AWM_SECT_WORDS) // [R3]
            begin
                mwv_nxt = 1'b1;
                mwd_nxt = tf.tf_wdata;
            end
            if (last_acc)
            begin
                wcnt_nxt = 9'd0;
                drq_nxt = 1'b0;
                bsy_nxt = 1'b1; // [R14]
                sto_nxt = 1'b1;
                st_nxt = D_STORE;
            end
        end
        case (st_r)
            D_SETUP:
            begin
                bsy_nxt = 1'b0;
                wcnt_nxt = 9'd0;
                blk_nxt = blk_sectors;
                long_nxt = (op_class(cmd_r) == 2'd1);
                if (op_class(cmd_r) == 2'd0 ||
                    (op_class(cmd_r) == 2'd2 && blk_sectors == 8'h00))
                begin
                    er_nxt[`AWM_ER_ABRT] = 1'b1; // [R16]
                    errb_nxt = 1'b1;
                    irq_nxt = 1'b1;
                    st_nxt = D_IDLE;
                end
                else
                begin
                    drq_nxt = 1'b1; // No interrupt here [R12]
                    st_nxt = D_XFER;
                    if (op_class(cmd_r) == 2'd1)
                        left_nxt = 9'd1; // [R2]
                    else if (sc_r == 8'h00)
                        left_nxt = `AWM_MAX_SECT; // [R13]
                    else
                        left_nxt = {1'b0, sc_r};
                end
            end
            D_STORE:
            begin
                if (med_ack)
                begin
                    sto_nxt = 1'b0;
                    bsy_nxt = 1'b0;
                    if (med_fail)
                    begin
                        // Address left pointing at failing sector [R15]
                        er_nxt[`AWM_ER_IDNF] = 1'b1;
                        errb_nxt = 1'b1;
                        irq_nxt = 1'b1;
                        st_nxt = D_IDLE;
                    end
                    else
                    begin
                        {dh_nxt[3:0], ch_nxt, cl_nxt, sn_nxt} = lba_inc;
                        left_nxt = left_r - 9'd1;
                        if (left_r == 9'd1)
                        begin
                            irq_nxt = 1'b1; // [R14]
                            st_nxt = D_IDLE;
                        end
                        else
                        begin
                            drq_nxt = 1'b1;
                            st_nxt = D_XFER;
                            if (blk_r == 8'h01)
                            begin
                                irq_nxt = 1'b1; // Block boundary [R7]
                                blk_nxt = blk_sectors;
                            end
                            else
                                blk_nxt = blk_r - 8'h01; // [R7] [R8]
                        end
                    end
                end
            end
            default:
                ;
        endcase
    end

    // State flops
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= D_IDLE;
            sc_r <= 8'h01;
            sn_r <= 8'h01;
            cl_r <= 8'h00;
            ch_r <= 8'h00;
            dh_r <= `AWM_DH_FIXED;
            cmd_r <= 8'h00;
            er_r <= 8'h00;
            blk_r <= 8'h00;
            bsy_r <= 1'b0;
            drq_r <= 1'b0;
            errb_r <= 1'b0;
            irq_r <= 1'b0;
            long_r <= 1'b0;
            left_r <= 9'd0;
            wcnt_r <= 9'd0;
            rd_r <= 16'h0000;
            mwd_r <= 16'h0000;
            mwv_r <= 1'b0;
            sto_r <= 1'b0;
        end
        else if (ce)
        begin
            st_r <= st_nxt;
            sc_r <= sc_nxt;
            sn_r <= sn_nxt;
            cl_r <= cl_nxt;
            ch_r <= ch_nxt;
            dh_r <= dh_nxt;
            cmd_r <= cmd_nxt;
            er_r <= er_nxt;
            blk_r <= blk_nxt;
            bsy_r <= bsy_nxt;
            drq_r <= drq_nxt;
            errb_r <= errb_nxt;
            irq_r <= irq_nxt;
            long_r <= long_nxt;
            left_r <= left_nxt;
            wcnt_r <= wcnt_nxt;
            rd_r <= rd_nxt;
            mwd_r <= mwd_nxt;
            mwv_r <= mwv_nxt;
            sto_r <= sto_nxt;
        end
    end
endmodule : awm_dev

// ===== rtl/awm_params.svh
// Constants of the long and multiple write command block
`ifndef AWM_PARAMS_SVH
`define AWM_PARAMS_SVH
// ==========================================================
// Task-file register offsets
`define AWM_TF_DATA 3'h0
`define AWM_TF_ERR 3'h1
`define AWM_TF_SC 3'h2
`define AWM_TF_SN 3'h3
`define AWM_TF_CL 3'h4
`define AWM_TF_CH 3'h5
`define AWM_TF_DH 3'h6
`define AWM_TF_CMD 3'h7
// ==========================================================
// Opcodes
`define AWM_OP_LONG_RTY 8'h32
`define AWM_OP_LONG_NORTY 8'h33
`define AWM_OP_MULT 8'hc5
// ==========================================================
// Status, error and drive/head register bits
`define AWM_ST_BSY 7
`define AWM_ST_DRDY 6
`define AWM_ST_DSC 4
`define AWM_ST_DRQ 3
`define AWM_ST_ERR 0
`define AWM_ER_IDNF 4
`define AWM_ER_ABRT 2
`define AWM_DH_LBA 6
`define AWM_DH_FIXED 8'ha0
// ==========================================================
// Transfer sizes
`define AWM_SECT_WORDS 9'd256
`define AWM_LONG_ACC 9'd260
`define AWM_ECC_BYTES 9'd4
`define AWM_MAX_SECT 9'd256
// ==========================================================
// Timing
`define AWM_CLK_NS 25
`define AWM_BSY_MAX_NS 400
// ==========================================================
// Controller register offsets and bits
`define AWM_HR_CTRL 3'h0
`define AWM_HR_LBA 3'h1
`define AWM_HR_CNT 3'h2
`define AWM_HR_STAT 3'h3
`define AWM_HR_ISTAT 3'h4
`define AWM_HR_ICLR 3'h5
`define AWM_HR_IEN 3'h6
`define AWM_EV_DONE 0
`define AWM_EV_FAIL 1
`endif

// ===== rtl/awm_pkg.sv
// Types shared by both ends of the task-file link
package awm_pkg;
    typedef logic [15:0] awm_word_t;
    typedef logic [7:0] awm_byte_t;
    typedef enum logic [1:0] {D_IDLE, D_SETUP, D_XFER, D_STORE} awm_dst_t;
    typedef enum logic [2:0] {H_IDLE, H_TFW, H_PRD, H_PWAIT, H_PCHK,
                              H_DATA, H_WIRQ} awm_hst_t;
endpackage : awm_pkg

// ===== rtl/awm_tf_if.sv
// Task-file link between host adapter and device
interface awm_tf_if;
    logic [2:0] tf_addr;
    logic [15:0] tf_wdata;
    logic tf_wr;
    logic tf_rd;
    logic [15:0] tf_rdata;
    logic intrq;
    modport dev (input tf_addr, input tf_wdata, input tf_wr, input tf_rd,
                 output tf_rdata, output intrq);
    modport hst (output tf_addr, output tf_wdata, output tf_wr,
                 output tf_rd, input tf_rdata, input intrq);
endinterface : awm_tf_if

// ===== rtl/awm_host.sv
// Host end: issues long and multiple writes over the task file
`include "awm_params.svh"
module awm_host (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // Software register port
    input wire logic [2:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    // Sector data source
    input wire logic src_valid,
    input wire awm_pkg::awm_word_t src_data,
    output logic src_ready,
    // Task-file link
    awm_tf_if.hst tf
);
    import awm_pkg::*;

    awm_hst_t st_r, st_nxt;
    logic [7:0] op_r, op_nxt, cnt_r, cnt_nxt, mult_r, mult_nxt;
    logic [27:0] lba_r, lba_nxt;
    logic [8:0] left_r, left_nxt, nsec;
    logic [16:0] bcnt_r, bcnt_nxt;
    logic [2:0] step_r, step_nxt, ta_r, ta_nxt;
    awm_word_t td_r, td_nxt;
    logic tw_r, tw_nxt, tr_r, tr_nxt, long_r, long_nxt;
    logic [7:0] dst_r, dst_nxt;
    logic [1:0] ist_r, ist_nxt, ien_r, ien_nxt, ev;
    logic [31:0] rdat_r, rdat_nxt;

    assign tf.tf_addr = ta_r;
    assign tf.tf_wdata = td_r;
    assign tf.tf_wr = tw_r;
    assign tf.tf_rd = tr_r;
    assign reg_rdata = rdat_r;
    assign irq = |(ist_r & ien_r);
    assign src_ready = (st_r == H_DATA) && ce;
    // Sectors in this burst: one block or what is left
    assign nsec = ({1'b0, mult_r} < left_r) ? {1'b0, mult_r} : left_r;

    // Next-state logic
    always_comb
    begin
        st_nxt = st_r;
        op_nxt = op_r;
        cnt_nxt = cnt_r;
        mult_nxt = mult_r;
        lba_nxt = lba_r;
        left_nxt = left_r;
        bcnt_nxt = bcnt_r;
        step_nxt = step_r;
        ta_nxt = ta_r;
        td_nxt = td_r;
        tw_nxt = 1'b0;
        tr_nxt = 1'b0;
        long_nxt = long_r;
        dst_nxt = dst_r;
        ien_nxt = ien_r;
        rdat_nxt = rdat_r;
        ev = 2'b00;
        if (reg_rd)
        begin
            if (reg_addr == `AWM_HR_CTRL)
                rdat_nxt = {16'h0000, op_r, 8'h00};
            else if (reg_addr == `AWM_HR_LBA)
                rdat_nxt = {4'h0, lba_r};
            else if (reg_addr == `AWM_HR_CNT)
                rdat_nxt = {16'h0000, mult_r, cnt_r};
            else if (reg_addr == `AWM_HR_STAT)
                rdat_nxt = {16'h0000, dst_r, 7'h00, st_r != H_IDLE};
            else if (reg_addr == `AWM_HR_ISTAT)
                rdat_nxt = {30'h0, ist_r};
            else if (reg_addr == `AWM_HR_IEN)
                rdat_nxt = {30'h0, ien_r};
            else
                rdat_nxt = 32'h0;
        end
        if (reg_wr && st_r == H_IDLE)
        begin
            if (reg_addr == `AWM_HR_LBA)
                lba_nxt = reg_wdata[27:0];
            else if (reg_addr == `AWM_HR_CNT)
                {mult_nxt, cnt_nxt} = reg_wdata[15:0];
            else if (reg_addr == `AWM_HR_CTRL && reg_wdata[0])
            begin
                op_nxt = reg_wdata[15:8];
                long_nxt = reg_wdata[15:8] == `AWM_OP_LONG_RTY ||
                           reg_wdata[15:8] == `AWM_OP_LONG_NORTY;
                if (long_nxt)
                    left_nxt = 9'd1;
                else if (cnt_r == 8'h00)
                    left_nxt = `AWM_MAX_SECT;
                else
                    left_nxt = {1'b0, cnt_r};
                // Refuse a multiple write with no block size [R9]
                if (reg_wdata[15:8] == `AWM_OP_MULT && mult_r == 8'h00)
                    ev[`AWM_EV_FAIL] = 1'b1;
                else
                begin
                    step_nxt = `AWM_TF_SC;
                    st_nxt = H_TFW;
                end
            end
        end
        if (reg_wr && reg_addr == `AWM_HR_IEN)
            ien_nxt = reg_wdata[1:0];
        case (st_r)
            H_TFW:
            begin
                // Address registers, then command [R11]
                tw_nxt = 1'b1;
                ta_nxt = step_r;
                step_nxt = step_r + 3'd1;
                if (step_r == `AWM_TF_SC)
                    td_nxt = {8'h00, cnt_r};
                else if (step_r == `AWM_TF_SN)
                    td_nxt = {8'h00, lba_r[7:0]};
                else if (step_r == `AWM_TF_CL)
                    td_nxt = {8'h00, lba_r[15:8]};
                else if (step_r == `AWM_TF_CH)
                    td_nxt = {8'h00, lba_r[23:16]};
                else if (step_r == `AWM_TF_DH)
                    td_nxt = {8'h00, `AWM_DH_FIXED | 8'h40 |
                              {4'h0, lba_r[27:24]}};
                else
                begin
                    td_nxt = {8'h00, op_r};
                    st_nxt = H_PRD;
                end
            end
            H_PRD:
            begin
                tr_nxt = 1'b1;
                ta_nxt = `AWM_TF_CMD;
                st_nxt = H_PWAIT;
            end
            H_PWAIT:
                st_nxt = H_PCHK;
            H_PCHK:
            begin
                dst_nxt = tf.tf_rdata[7:0];
                if (tf.tf_rdata[`AWM_ST_BSY])
                    st_nxt = H_PRD;
                else if (tf.tf_rdata[`AWM_ST_ERR])
                begin
                    ev[`AWM_EV_FAIL] = 1'b1;
                    st_nxt = H_IDLE;
                end
                else if (tf.tf_rdata[`AWM_ST_DRQ] && left_r != 9'd0)
                begin
                    // Data request checked once per block [R8]
                    st_nxt = H_DATA;
                    if (long_r)
                        bcnt_nxt = {8'h00, `AWM_LONG_ACC}; // [R1]
                    else
                        bcnt_nxt = {nsec, 8'h00};
                    left_nxt = long_r ? 9'd0 : left_r - nsec;
                end
                else
                begin
                    ev[`AWM_EV_DONE] = 1'b1;
                    st_nxt = H_IDLE;
                end
            end
            H_DATA:
            begin
                if (src_valid)
                begin
                    tw_nxt = 1'b1;
                    ta_nxt = `AWM_TF_DATA;
                    // Last four accesses of a long sector are bytes [R3]
                    if (long_r && bcnt_r <= {8'h00, `AWM_ECC_BYTES})
                        td_nxt = {8'h00, src_data[7:0]};
                    else
                        td_nxt = src_data;
                    bcnt_nxt = bcnt_r - 17'd1;
                    if (bcnt_r == 17'd1)
                        st_nxt = H_WIRQ;
                end
            end
            H_WIRQ:
                if (tf.intrq)
                    st_nxt = H_PRD;
            default:
                ;
        endcase
        // New events win over a clear in the same cycle
        ist_nxt = ist_r;
        if (reg_wr && reg_addr == `AWM_HR_ICLR)
            ist_nxt = ist_r & ~reg_wdata[1:0];
        ist_nxt = ist_nxt | ev;
    end

    // State flops
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= H_IDLE;
            op_r <= 8'h00;
            cnt_r <= 8'h01;
            mult_r <= 8'h00;
            lba_r <= 28'h0;
            left_r <= 9'd0;
            bcnt_r <= 17'd0;
            step_r <= 3'd0;
            ta_r <= 3'd0;
            td_r <= 16'h0000;
            tw_r <= 1'b0;
            tr_r <= 1'b0;
            long_r <= 1'b0;
            dst_r <= 8'h00;
            ist_r <= 2'b00;
            ien_r <= 2'b00;
            rdat_r <= 32'h0;
        end
        else if (ce)
        begin
            st_r <= st_nxt;
            op_r <= op_nxt;
            cnt_r <= cnt_nxt;
            mult_r <= mult_nxt;
            lba_r <= lba_nxt;
            left_r <= left_nxt;
            bcnt_r <= bcnt_nxt;
            step_r <= step_nxt;
            ta_r <= ta_nxt;
            td_r <= td_nxt;
            tw_r <= tw_nxt;
            tr_r <= tr_nxt;
            long_r <= long_nxt;
            dst_r <= dst_nxt;
            ist_r <= ist_nxt;
            ien_r <= ien_nxt;
            rdat_r <= rdat_nxt;
        end
    end
endmodule : awm_host

// ===== testbench/awm_props.sv
// Checker of the task-file link and the device media handshake
module awm_props (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Task-file link
    input wire logic [2:0] tf_addr,
    input wire logic [15:0] tf_wdata,
    input wire logic tf_wr,
    input wire logic tf_rd,
    input wire logic [15:0] tf_rdata,
    input wire logic intrq,
    // Media side of the device
    input wire logic med_wvalid,
    input wire logic [15:0] med_wdata,
    input wire logic med_retry,
    input wire logic med_store,
    input wire logic med_ack
);
    // ======================================================
    // Clocking and named steps
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    sequence s_cmd;
        tf_wr && tf_addr == 3'h7;
    endsequence
    sequence s_stat;
        tf_rd && tf_addr == 3'h7;
    endsequence
    // ======================================================
    // Properties
    a_word_fwd: assert property (med_wvalid |-> $past(tf_wr) &&
        $past(tf_addr) == 3'h0 && med_wdata == $past(tf_wdata))
        else $error("stray media word");
    a_store_hold: assert property (med_store && !med_ack |=>
        med_store) else $error("store dropped");
    a_store_end: assert property (med_store && med_ack |=>
        !med_store) else $error("store kept");
    a_stat_clear: assert property (s_stat and intrq |=> !intrq)
        else $error("interrupt kept");
    a_cmd_quiet: assert property (s_cmd |=> !intrq)
        else $error("early interrupt");
    a_irq_cause: assert property ($rose(intrq) |-> $past(med_ack) ||
        $past(med_ack, 2) || $past(tf_wr, 2) || $past(tf_wr, 3))
        else $error("stray interrupt");
    a_stat_fixed: assert property (s_stat |=>
        tf_rdata[6:4] == 3'b101 && tf_rdata[2:1] == 2'b00)
        else $error("fixed status bits wrong");
    a_retry_on: assert property (s_cmd and tf_wdata[7:0] == 8'h32 |=>
        med_retry) else $error("retry missing");
    a_retry_off: assert property (s_cmd and tf_wdata[7:0] == 8'h33 |=>
        !med_retry) else $error("retry not dropped");
endmodule : awm_props

// ===== testbench/ata_write_long_and_multiple_tb.sv
// Self-checking bench of host and device ends joined by the task file
module ata_write_long_and_multiple_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import awm_pkg::*;
    // ======================================================
    // Signals and model state
    logic clk_sys, rst_n, reg_wr, reg_rd, irq, src_valid, src_ready;
    logic med_wvalid, med_lba_mode, med_retry, med_store, med_ack, med_fail;
    logic [2:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [27:0] med_lba;
    awm_word_t src_data, med_wdata;
    awm_byte_t blk_sectors;
    int miscompares, comparisons, widx, stcnt, fail_at, nirq;
    bit long_m, iq_q;
    logic [7:0] cop;
    awm_word_t wq[$];
    logic [27:0] lq[$];
    awm_tf_if tf_i ();
    awm_dev awm_dev_i (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1),
        .tf(tf_i.dev), .blk_sectors(blk_sectors), .med_wvalid(med_wvalid),
        .med_wdata(med_wdata), .med_lba(med_lba), .med_lba_mode(med_lba_mode),
        .med_retry(med_retry), .med_store(med_store), .med_ack(med_ack),
        .med_fail(med_fail));
    awm_host awm_host_i (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .src_valid(src_valid), .src_data(src_data), .src_ready(src_ready),
        .tf(tf_i.hst));
    awm_props awm_props_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .tf_addr(tf_i.tf_addr), .tf_wdata(tf_i.tf_wdata), .tf_wr(tf_i.tf_wr),
        .tf_rd(tf_i.tf_rd), .tf_rdata(tf_i.tf_rdata), .intrq(tf_i.intrq),
        .med_wvalid(med_wvalid), .med_wdata(med_wdata), .med_retry(med_retry),
        .med_store(med_store), .med_ack(med_ack));
    // ======================================================
    // Clock, compare and register port tasks
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    // Data stand the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask : rd
    task automatic results;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results
    // One command, its checks, then clear
    task automatic run(input logic [7:0] op, input int cnt, blk, dblk, nst,
                       ien, ist, nint, fat);
        logic [31:0] d;
        logic [27:0] lba;
        int n;
        lba = 28'($urandom);
        cop = op;
        long_m = op != 8'hc5;
        widx = 0;
        stcnt = 0;
        nirq = 0;
        fail_at = fat;
        blk_sectors <= dblk[7:0];
        for (int i = 0; i < nst; i++)
            lq.push_back(lba + 28'(i));
        wr(3'h6, ien);
        wr(3'h1, {4'h0, lba});
        wr(3'h2, {16'h0, blk[7:0], cnt[7:0]});
        wr(3'h0, {16'h0, op, 8'h01});
        n = 0;
        d = 0;
        while (d[1:0] == 2'b00 && n < 3000)
        begin
            rd(3'h4, d);
            n++;
        end
        chk(d, ist);
        chk(irq, (ist & ien) != 0);
        chk(nirq, nint);
        chk(wq.size() + lq.size(), 0);
        chk(med_lba, lba + 28'(nst - (fat != 0)));
        wr(3'h5, 32'h3);
        rd(3'h4, d);
        chk(d, 0);
        chk(irq, 0);
        $display("test op %h done", op);
    endtask : run
    // ======================================================
    // Source; long writes keep 256 words
    always @(posedge clk_sys)
    begin
        if (src_valid && src_ready)
        begin
            if (!long_m || widx < 256)
                wq.push_back(src_data);
            widx++;
        end
        if (!src_valid || src_ready)
        begin
            src_valid <= ($urandom % 4) != 0;
            src_data <= awm_word_t'($urandom);
        end
    end
    // Media model and output checks
    always @(posedge clk_sys)
    begin
        if (med_wvalid)
            chk(med_wdata, wq.pop_front());
        if (med_store && med_ack)
            chk({med_lba_mode, med_retry, med_lba},
                {1'b1, cop != 8'h33, lq.pop_front()});
        med_ack <= 1'b0;
        if (med_store && !med_ack && $urandom % 3 == 0)
        begin
            stcnt++;
            med_ack <= 1'b1;
            med_fail <= stcnt == fail_at;
        end
        if (tf_i.intrq && !iq_q)
            nirq++;
        iq_q <= tf_i.intrq;
    end
    // Watchdog well past the longest run
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        miscompares++;
        results();
    end
    // ======================================================
    // Main sequence
    initial
    begin
        logic [31:0] d;
        void'($urandom(9769));
        {rst_n, reg_wr, reg_rd, med_ack, med_fail, src_valid} = 6'h0;
        reg_addr = 3'h0;
        reg_wdata = 32'h0;
        src_data = 16'h0;
        blk_sectors = 8'h0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        run(8'h32, 3, 1, 2, 1, 3, 1, 1, 0);
        run(8'h33, 1, 1, 2, 1, 0, 1, 1, 0);
        run(8'hc5, 3, 2, 2, 3, 3, 1, 2, 0);
        run(8'hc5, 3, 2, 2, 2, 1, 2, 1, 2);
        run(8'hc5, 2, 2, 0, 0, 3, 2, 1, 0);
        rd(3'h3, d);
        chk(d[8], 1'b1);
        rd(3'h7, d);
        chk(d, 0);
        results();
    end
endmodule : ata_write_long_and_multiple_tb
